//--- logic/tcd_pkg.sv
// constants for the two-channel transfer request controller
package tcd_pkg;
    // register index map, word addressed
    localparam int unsigned REG_AW = 5;
    localparam logic [REG_AW-1:0] CH_STRIDE = 5'h08;
    localparam logic [2:0] RG_CTRL = 3'h0;
    localparam logic [2:0] RG_SEL = 3'h1;
    localparam logic [2:0] RG_SRC = 3'h2;
    localparam logic [2:0] RG_DST = 3'h3;
    localparam logic [2:0] RG_RELOAD = 3'h4;
    localparam logic [2:0] RG_FWD = 3'h5;
    localparam logic [2:0] RG_CNT = 3'h6;
    localparam logic [REG_AW-1:0] RG_IRQ_STAT = 5'h10;
    localparam logic [REG_AW-1:0] RG_IRQ_MASK = 5'h11;
    // control register fields
    localparam int unsigned CTL_EN = 0;
    localparam int unsigned CTL_REPEAT = 1;
    localparam int unsigned CTL_FWD_DST = 2;
    localparam int unsigned CTL_REQ = 3;
    localparam int unsigned CTL_SOFT = 4;
    // source select fields: kind in [1:0], peripheral index in [4:2]
    localparam int unsigned SEL_KIND_LSB = 0;
    localparam int unsigned SEL_PER_LSB = 2;
    localparam logic [1:0] KIND_SOFT = 2'h0;
    localparam logic [1:0] KIND_PERIPH = 2'h1;
    localparam logic [1:0] KIND_EXT_FALL = 2'h2;
    localparam logic [1:0] KIND_EXT_BOTH = 2'h3;
    // reset values
    localparam logic [4:0] SEL_RESET = 5'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [1:0] MASK_RESET = 2'h0;
    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_READ, ST_LATCH, ST_WRITE, ST_DONE, ST_YIELD
    } tcd_state_t;
endpackage : tcd_pkg

//--- logic/tcd_req.sv
// per-channel request source selection and sticky request flag
module tcd_req #(
    parameter int unsigned NPER = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // selection
    input wire logic [1:0] kind,
    input wire logic [2:0] per_idx,
    // request sources
    input wire logic [NPER-1:0] periph_irq,
    input wire logic ext_pin,
    input wire logic soft_trig,
    // flag control
    input wire logic sw_clear,
    input wire logic hw_clear,
    output logic event_now,
    output logic flag
);
    logic sync1_r;
    logic sync2_r;
    logic edge_r;
    logic per_hit;

    // pin is asynchronous: two stages before the edge detector
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            edge_r <= 1'b1;
        end else begin
            sync1_r <= ext_pin;
            sync2_r <= sync1_r;
            edge_r <= sync2_r;
        end
    end

    assign per_hit = periph_irq[per_idx];

    always_comb begin
        unique case (kind)
            tcd_pkg::KIND_SOFT: event_now = soft_trig;
            tcd_pkg::KIND_PERIPH: event_now = per_hit;
            tcd_pkg::KIND_EXT_FALL: event_now = edge_r & ~sync2_r;
            tcd_pkg::KIND_EXT_BOTH: event_now = edge_r ^ sync2_r;
        endcase
    end

    // a new event beats a clear in the same cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else if (event_now) begin
            flag <= 1'b1;
        end else if (sw_clear || hw_clear) begin
            flag <= 1'b0;
        end
    end
endmodule : tcd_req

//--- logic/tcd_ctrl.sv
// two-channel transfer controller: activation, requests, priority, bus hand-back
// What this block does
// - enable write activates; first transfer loads forward pointer from incrementing pointer
// - first transfer after activation loads counter from reload register
// - writing one to enable again repeats both reloads at next transfer
// - each channel requests from one preselected internal or external source
// - request flag sets on its event whether enabled or not
// - hardware clears request flag just before its transfer starts
// - software may write zero to clear the flag; writing one does nothing
// - peripheral requests set the flag with their interrupt request timing
// - external pin requests set the flag on the selected pin edge
// - simultaneous requests set both flags; channel zero transfers first
// - each transfer returns the bus; a channel pending at hand-back waits for one CPU access
// - single mode: underflow clears enable, channel goes inactive
// - repeat mode: underflow reloads counter, channel stays active
// - underflow raises the channel interrupt request
module tcd_ctrl #(
    parameter int unsigned AW = 16,
    parameter int unsigned DW = 16,
    parameter int unsigned CW = 16,
    parameter int unsigned NPER = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [tcd_pkg::REG_AW-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // request sources
    input wire logic [NPER-1:0] periph_irq,
    input wire logic [1:0] ext_irq_pin,
    // memory bus
    input wire logic cpu_access_done,
    output logic bus_hold,
    output logic [AW-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [DW-1:0] mem_wdata,
    input wire logic [DW-1:0] mem_rdata,
    // interrupt
    output logic irq
);
    tcd_pkg::tcd_state_t state_r;
    logic cur_r;
    logic [1:0] en_r;
    logic [1:0] repeat_r;
    logic [1:0] fwd_dst_r;
    logic [1:0] reload_pend_r;
    logic [4:0] sel_r [2];
    logic [AW-1:0] src_r [2];
    logic [AW-1:0] dst_r [2];
    logic [AW-1:0] fwd_r [2];
    logic [CW-1:0] reload_r [2];
    logic [CW-1:0] cnt_r [2];
    logic [DW-1:0] data_r;
    logic [1:0] irq_st_r;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_st_nxt;
    logic [1:0] flag;
    logic [1:0] ev;
    logic [1:0] go;
    logic [1:0] ctrl_wr;
    logic [1:0] hw_clear;
    logic [1:0] underflow;
    logic stat_rd;
    logic [AW-1:0] src_addr;
    logic [AW-1:0] dst_addr;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            ctrl_wr[c] = reg_wr && reg_addr == ((c == 0) ? 5'h00 : tcd_pkg::CH_STRIDE);
            go[c] = en_r[c] & flag[c];
            hw_clear[c] = (state_r == tcd_pkg::ST_START) && (cur_r == c[0]);
            underflow[c] = (state_r == tcd_pkg::ST_DONE) && (cur_r == c[0])
                && (cnt_r[c] == '0);
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_req
        tcd_req #(.NPER(NPER)) u_req (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .kind(sel_r[g][tcd_pkg::SEL_KIND_LSB +: 2]),
            .per_idx(sel_r[g][tcd_pkg::SEL_PER_LSB +: 3]),
            .periph_irq(periph_irq),
            .ext_pin(ext_irq_pin[g]),
            .soft_trig(ctrl_wr[g] && reg_wdata[tcd_pkg::CTL_SOFT]),
            .sw_clear(ctrl_wr[g] && !reg_wdata[tcd_pkg::CTL_REQ]),
            .hw_clear(hw_clear[g]),
            .event_now(ev[g]),
            .flag(flag[g])
        );
    end

    // the fixed side uses its own pointer, the incrementing side the working pointer
    assign src_addr = fwd_dst_r[cur_r] ? src_r[cur_r] : fwd_r[cur_r];
    assign dst_addr = fwd_dst_r[cur_r] ? fwd_r[cur_r] : dst_r[cur_r];

    // channel configuration registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            repeat_r <= 2'h0;
            fwd_dst_r <= 2'h0;
            for (int c = 0; c < 2; c++) begin
                sel_r[c] <= tcd_pkg::SEL_RESET;
                src_r[c] <= AW'(tcd_pkg::WORD_RESET);
                dst_r[c] <= AW'(tcd_pkg::WORD_RESET);
                reload_r[c] <= CW'(tcd_pkg::WORD_RESET);
            end
        end else if (reg_wr) begin
            for (int c = 0; c < 2; c++) begin
                if (reg_addr[4] == 1'b0 && reg_addr[3] == c[0]) begin
                    unique case (reg_addr[2:0])
                        tcd_pkg::RG_CTRL: begin
                            repeat_r[c] <= reg_wdata[tcd_pkg::CTL_REPEAT];
                            fwd_dst_r[c] <= reg_wdata[tcd_pkg::CTL_FWD_DST];
                        end
                        tcd_pkg::RG_SEL: sel_r[c] <= reg_wdata[4:0];
                        // a fixed-address pointer only takes writes while its channel is disabled
                        tcd_pkg::RG_SRC: begin
                            if (!fwd_dst_r[c] || !en_r[c]) begin
                                src_r[c] <= reg_wdata[AW-1:0];
                            end
                        end
                        tcd_pkg::RG_DST: begin
                            if (fwd_dst_r[c] || !en_r[c]) begin
                                dst_r[c] <= reg_wdata[AW-1:0];
                            end
                        end
                        tcd_pkg::RG_RELOAD: reload_r[c] <= reg_wdata[CW-1:0];
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // enable, reload and working counters
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            en_r <= 2'h0;
            reload_pend_r <= 2'h0;
            for (int c = 0; c < 2; c++) begin
                fwd_r[c] <= AW'(tcd_pkg::WORD_RESET);
                cnt_r[c] <= CW'(tcd_pkg::WORD_RESET);
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (hw_clear[c] && reload_pend_r[c]) begin
                    fwd_r[c] <= fwd_dst_r[c] ? dst_r[c] : src_r[c];
                    cnt_r[c] <= reload_r[c];
                    reload_pend_r[c] <= 1'b0;
                end
                if (state_r == tcd_pkg::ST_DONE && cur_r == c[0]) begin
                    fwd_r[c] <= fwd_r[c] + AW'(1);
                    if (underflow[c] && repeat_r[c]) begin
                        cnt_r[c] <= reload_r[c];
                    end else if (underflow[c]) begin
                        en_r[c] <= 1'b0;
                    end else begin
                        cnt_r[c] <= cnt_r[c] - CW'(1);
                    end
                end
                // a fresh software write overrides the hardware update
                if (ctrl_wr[c]) begin
                    en_r[c] <= reg_wdata[tcd_pkg::CTL_EN];
                    if (reg_wdata[tcd_pkg::CTL_EN]) begin
                        reload_pend_r[c] <= 1'b1;
                    end
                end
            end
        end
    end

    // transfer sequencer
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= tcd_pkg::ST_IDLE;
            cur_r <= 1'b0;
            bus_hold <= 1'b0;
            mem_addr <= '0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= '0;
            data_r <= '0;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            unique case (state_r)
                tcd_pkg::ST_IDLE: begin
                    if (go != 2'h0) begin
                        cur_r <= !go[0];
                        bus_hold <= 1'b1;
                        state_r <= tcd_pkg::ST_START;
                    end
                end
                tcd_pkg::ST_START: state_r <= tcd_pkg::ST_READ;
                tcd_pkg::ST_READ: begin
                    mem_addr <= src_addr;
                    mem_rd <= 1'b1;
                    state_r <= tcd_pkg::ST_LATCH;
                end
                tcd_pkg::ST_LATCH: state_r <= tcd_pkg::ST_WRITE;
                tcd_pkg::ST_WRITE: begin
                    data_r <= mem_rdata;
                    mem_addr <= dst_addr;
                    mem_wdata <= mem_rdata;
                    mem_wr <= 1'b1;
                    state_r <= tcd_pkg::ST_DONE;
                end
                tcd_pkg::ST_DONE: begin
                    bus_hold <= 1'b0;
                    state_r <= tcd_pkg::ST_YIELD;
                end
                tcd_pkg::ST_YIELD: begin
                    // a pending channel waits for one cpu access before taking the bus
                    if (go == 2'h0 || cpu_access_done) begin
                        state_r <= tcd_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // interrupt status, read-to-clear, set wins over the clear
    assign stat_rd = reg_rd && reg_addr == tcd_pkg::RG_IRQ_STAT;
    assign irq_st_nxt = (stat_rd ? 2'h0 : irq_st_r) | underflow;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_st_r <= 2'h0;
            irq_mask_r <= tcd_pkg::MASK_RESET;
            irq <= 1'b0;
        end else begin
            irq_st_r <= irq_st_nxt;
            if (reg_wr && reg_addr == tcd_pkg::RG_IRQ_MASK) begin
                irq_mask_r <= reg_wdata[1:0];
                irq <= |(irq_st_nxt & reg_wdata[1:0]);
            end else begin
                irq <= |(irq_st_nxt & irq_mask_r);
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == tcd_pkg::RG_IRQ_STAT) begin
            reg_rdata <= {14'h0000, irq_st_r};
        end else if (reg_addr == tcd_pkg::RG_IRQ_MASK) begin
            reg_rdata <= {14'h0000, irq_mask_r};
        end else if (reg_addr[4]) begin
            reg_rdata <= 16'h0000;
        end else begin
            unique case (reg_addr[2:0])
                tcd_pkg::RG_CTRL: reg_rdata <= {12'h000, flag[reg_addr[3]],
                    fwd_dst_r[reg_addr[3]], repeat_r[reg_addr[3]], en_r[reg_addr[3]]};
                tcd_pkg::RG_SEL: reg_rdata <= {11'h000, sel_r[reg_addr[3]]};
                tcd_pkg::RG_SRC: reg_rdata <= 16'(
                    (en_r[reg_addr[3]] && !fwd_dst_r[reg_addr[3]])
                    ? fwd_r[reg_addr[3]] : src_r[reg_addr[3]]);
                tcd_pkg::RG_DST: reg_rdata <= 16'(
                    (en_r[reg_addr[3]] && fwd_dst_r[reg_addr[3]])
                    ? fwd_r[reg_addr[3]] : dst_r[reg_addr[3]]);
                tcd_pkg::RG_RELOAD: reg_rdata <= 16'(reload_r[reg_addr[3]]);
                tcd_pkg::RG_FWD: reg_rdata <= 16'(fwd_r[reg_addr[3]]);
                tcd_pkg::RG_CNT: reg_rdata <= 16'(cnt_r[reg_addr[3]]);
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    a_enable_activates: assert property (@(posedge mclk) disable iff (sys_rst)
        (ctrl_wr[0] && reg_wdata[tcd_pkg::CTL_EN]) |=> (en_r[0] && reload_pend_r[0]))
        else $error("enable write did not activate channel zero");
    a_pointer_reload: assert property (@(posedge mclk) disable iff (sys_rst)
        (hw_clear[0] && reload_pend_r[0] && !ctrl_wr[0]) |=>
        (fwd_r[0] == (fwd_dst_r[0] ? dst_r[0] : src_r[0])))
        else $error("forward pointer not reloaded on first transfer");
    a_count_reload: assert property (@(posedge mclk) disable iff (sys_rst)
        (hw_clear[1] && reload_pend_r[1] && !reg_wr) |=> (cnt_r[1] == $past(reload_r[1])))
        else $error("counter not reloaded on first transfer");
    a_rewrite_restart: assert property (@(posedge mclk) disable iff (sys_rst)
        (en_r[1] && ctrl_wr[1] && reg_wdata[tcd_pkg::CTL_EN]) |=>
        (reload_pend_r[1] until_with hw_clear[1]))
        else $error("second enable write lost its reload");
    a_flag_sets: assert property (@(posedge mclk) disable iff (sys_rst)
        ev[0] |=> flag[0])
        else $error("request event did not set flag");
    a_flag_hw_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        (hw_clear[0] && !ev[0]) |=> !flag[0])
        else $error("flag not cleared at transfer start");
    a_flag_sw_write: assert property (@(posedge mclk) disable iff (sys_rst)
        (ctrl_wr[0] && reg_wdata[tcd_pkg::CTL_REQ] && !reg_wdata[tcd_pkg::CTL_SOFT]
        && !hw_clear[0] && !ev[0]) |=> (flag[0] == $past(flag[0])))
        else $error("writing one changed the request flag");
    a_prio_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_r == tcd_pkg::ST_IDLE && go == 2'h3) |=> (cur_r == 1'b0 && hw_clear[0]))
        else $error("channel one served before channel zero");
    a_bus_return: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_r == tcd_pkg::ST_DONE || (state_r == tcd_pkg::ST_YIELD && go != 2'h0
        && !cpu_access_done)) |=> (!bus_hold && state_r == tcd_pkg::ST_YIELD))
        else $error("bus not handed back between transfers");
    a_single_stop: assert property (@(posedge mclk) disable iff (sys_rst)
        (underflow[0] && !repeat_r[0] && !ctrl_wr[0]) |=> !en_r[0])
        else $error("single mode stayed active after underflow");
    a_repeat_stay: assert property (@(posedge mclk) disable iff (sys_rst)
        (underflow[1] && repeat_r[1] && !reg_wr) |=> (en_r[1] && cnt_r[1] == reload_r[1]))
        else $error("repeat mode did not reload on underflow");
    a_underflow_irq: assert property (@(posedge mclk) disable iff (sys_rst)
        (underflow[0] && irq_mask_r[0] && !reg_wr) |=> (irq_st_r[0] && irq))
        else $error("underflow raised no interrupt");
endmodule : tcd_ctrl

//--- test/tcd_mem_model.sv
// memory and cpu model on the far side of the transfer controller
module tcd_mem_model (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // memory bus
    input wire logic bus_hold,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    // cpu side
    input wire logic [3:0] cpu_wait,
    output logic cpu_access_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [256];
    logic hold_cnt;
    logic hold_q;
    logic waiting;
    logic [3:0] wait_cnt;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h5a00 + 16'(i);
        end
    end
    always @(posedge mclk) begin
        if (mem_wr) begin
            mem[mem_addr[7:0]] <= mem_wdata;
        end
    end
    // read data holds two cycles, then toggles so a late sample never looks valid
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_rdata <= 16'h0000;
            hold_cnt <= 1'b0;
        end else if (mem_rd) begin
            mem_rdata <= mem[mem_addr[7:0]];
            hold_cnt <= 1'b1;
        end else if (hold_cnt) begin
            hold_cnt <= 1'b0;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
    // the cpu makes one access some cycles after it gets the bus back
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_q <= 1'b0;
            waiting <= 1'b0;
            wait_cnt <= 4'h0;
            cpu_access_done <= 1'b0;
        end else begin
            hold_q <= bus_hold;
            cpu_access_done <= 1'b0;
            if (hold_q && !bus_hold) begin
                waiting <= 1'b1;
                wait_cnt <= cpu_wait;
            end else if (waiting) begin
                if (wait_cnt == 4'h0) begin
                    cpu_access_done <= 1'b1;
                    waiting <= 1'b0;
                end else begin
                    wait_cnt <= wait_cnt - 4'h1;
                end
            end
        end
    end
endmodule : tcd_mem_model

//--- test/tcd_ctrl_test.sv
// self-checking bench of the two-channel transfer controller
module tcd_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [tcd_pkg::REG_AW-1:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [7:0] periph_irq = '0;
    logic [1:0] ext_irq_pin = 2'h3;
    logic cpu_access_done, bus_hold, mem_rd, mem_wr, irq, hold_q = 1'b0, cpu_seen = 1'b0;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    logic [3:0] cpu_wait = 4'h1;
    logic [15:0] wq[$];
    logic rq[$];
    int falls = 0;
    int num_errors = 0;
    int n_checks = 0;
    always #10 mclk = ~mclk;
    tcd_ctrl dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .periph_irq(periph_irq), .ext_irq_pin(ext_irq_pin),
        .cpu_access_done(cpu_access_done), .bus_hold(bus_hold), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .irq(irq));
    tcd_mem_model mem_u (.mclk(mclk), .sys_rst(sys_rst), .bus_hold(bus_hold),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .cpu_wait(cpu_wait), .cpu_access_done(cpu_access_done));
    // write order and whether the cpu got an access in before each bus grab
    always @(posedge mclk) begin
        hold_q <= bus_hold;
        if (hold_q && !bus_hold) falls <= falls + 1;
        if (mem_wr) wq.push_back(mem_addr);
        if (bus_hold && !hold_q) begin
            rq.push_back(cpu_seen);
            cpu_seen <= 1'b0;
        end else if (cpu_access_done) begin
            cpu_seen <= 1'b1;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic pulse_per(input int idx);
        @(posedge mclk);
        periph_irq <= 8'h01 << idx;
        @(posedge mclk);
        periph_irq <= 8'h00;
    endtask : pulse_per
    // bounded wait for n bus releases, plus time for status and irq to settle
    task automatic wait_xfer(input int n);
        int target;
        target = falls + n;
        for (int k = 0; k < 400 && falls < target; k++) @(posedge mclk);
        if (falls < target) chk(16'(falls), 16'(target));
        repeat (3) @(posedge mclk);
    endtask : wait_xfer
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    initial begin
        #300us;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(5'h00, 16'h0000);
        rd(tcd_pkg::RG_IRQ_MASK, 16'h0000);
        rd(5'h1f, 16'h0000);
        // single mode on a peripheral source
        wr(5'h01, 16'h000d);
        wr(5'h02, 16'h0020);
        wr(5'h03, 16'h0030);
        wr(5'h04, 16'h0001);
        wr(tcd_pkg::RG_IRQ_MASK, 16'h0003);
        wr(5'h00, 16'h0000);
        pulse_per(2);
        rd(5'h00, 16'h0000);
        pulse_per(3);
        rd(5'h00, 16'h0008);
        wr(5'h00, 16'h0008);
        rd(5'h00, 16'h0008);
        wr(5'h00, 16'h0001);
        rd(5'h00, 16'h0001);
        pulse_per(3);
        wait_xfer(1);
        chk(mem_u.mem[8'h30], 16'h5a20);
        rd(5'h05, 16'h0021);
        rd(5'h06, 16'h0000);
        rd(5'h00, 16'h0001);
        pulse_per(3);
        wait_xfer(1);
        chk(mem_u.mem[8'h30], 16'h5a21);
        chk({15'h0, irq}, 16'h0001);
        rd(5'h00, 16'h0000);
        rd(tcd_pkg::RG_IRQ_STAT, 16'h0001);
        @(posedge mclk);
        #1 chk({15'h0, irq}, 16'h0000);
        $display("test single done");
        // repeat mode with restart; interrupt masked
        wr(tcd_pkg::RG_IRQ_MASK, 16'h0000);
        wr(5'h0a, 16'h0040);
        wr(5'h0b, 16'h0050);
        wr(5'h0c, 16'h0000);
        wr(5'h08, 16'h0017);
        wait_xfer(1);
        chk(mem_u.mem[8'h50], 16'h5a40);
        rd(5'h08, 16'h0007);
        rd(5'h0e, 16'h0000);
        rd(5'h0d, 16'h0051);
        chk({15'h0, irq}, 16'h0000);
        rd(tcd_pkg::RG_IRQ_STAT, 16'h0002);
        wr(5'h0b, 16'h0058);
        wr(5'h0a, 16'h0044);
        rd(5'h0a, 16'h0040);
        wr(5'h08, 16'h0017);
        wait_xfer(1);
        chk(mem_u.mem[8'h58], 16'h5a40);
        rd(5'h0d, 16'h0059);
        rd(tcd_pkg::RG_IRQ_STAT, 16'h0002);
        wr(5'h08, 16'h0000);
        $display("test repeat done");
        // both external pins fall together, the cpu slow to take its access
        cpu_wait <= 4'h6;
        wr(5'h01, 16'h0002);
        wr(5'h09, 16'h0002);
        wr(5'h02, 16'h0060);
        wr(5'h03, 16'h0070);
        wr(5'h04, 16'h0000);
        wr(5'h0a, 16'h0061);
        wr(5'h0b, 16'h0071);
        wr(5'h00, 16'h0001);
        wr(5'h08, 16'h0001);
        wq.delete();
        rq.delete();
        @(posedge mclk);
        ext_irq_pin <= 2'h0;
        wait_xfer(2);
        chk(wq[0], 16'h0070);
        chk(wq[1], 16'h0071);
        chk({15'h0, rq[1]}, 16'h0001);
        chk(mem_u.mem[8'h71], 16'h5a61);
        rd(5'h08, 16'h0000);
        rd(tcd_pkg::RG_IRQ_STAT, 16'h0003);
        wr(5'h09, 16'h0003);
        wr(5'h08, 16'h0000);
        ext_irq_pin <= 2'h3;
        repeat (4) @(posedge mclk);
        rd(5'h08, 16'h0008);
        rd(5'h00, 16'h0000);
        $display("test external done");
        stop_test();
    end
endmodule : tcd_ctrl_test
